/* ffls_defs.svh */
// Timing counts, step multiples and burst constants of the light-load sequencer
`ifndef FFLS_DEFS_SVH
`define FFLS_DEFS_SVH

`define FFLS_CLK_NS 50
`define FFLS_FRT_NS 2000
`define FFLS_FRT_CYC (`FFLS_FRT_NS / `FFLS_CLK_NS)
`define FFLS_BASE_MIN_NS 800
`define FFLS_BASE_MAX_NS 2200
`define FFLS_BASE_MIN_CYC ((`FFLS_BASE_MIN_NS + `FFLS_CLK_NS - 1) / `FFLS_CLK_NS)
`define FFLS_BASE_MAX_CYC (`FFLS_BASE_MAX_NS / `FFLS_CLK_NS)
`define FFLS_BM_FREQ_HZ 25000
`define FFLS_BM_PER_CYC (1000000000 / (`FFLS_BM_FREQ_HZ * `FFLS_CLK_NS))
`define FFLS_OSC45_NUM 80
`define FFLS_OSC45_DEN 1000
`define FFLS_STEP_COUNT 5
`define FFLS_STEP_MAX 3'h4
`define FFLS_LONG_MULT 10
`define FFLS_MULT_STEP 2
`define FFLS_MIN_BURST 6'h03
`define FFLS_MAX_BURST 6'h20
`define FFLS_CLAMP_P1 6'h02
`define FFLS_CLAMP_P2 6'h09
`define FFLS_CLAMP_P3 6'h10
`define FFLS_CLAMP_P4 6'h18
`define FFLS_CLAMP_P5 6'h20
`define FFLS_DEAD_CYC 12'h002
`define FFLS_RECH_CYC 12'h004
`define FFLS_REV_CYC 12'h006
`define FFLS_VCOMP_BM_CODE 8'h40
`define FFLS_VCOMP_45_CODE 8'hc0

`endif

/* ffls_pkg.sv */
// Types shared by the light-load sequencer
package ffls_pkg;
  typedef logic [2:0] ffls_step_t;
  typedef enum logic [2:0] {ST_DEAD, ST_MAIN, ST_RECH, ST_WAIT, ST_CLAMP, ST_IDLE} ffls_state_t;
  typedef struct packed {
    ffls_state_t st;
    logic main_sw;
    logic clamp_sw;
    ffls_step_t step;
    logic [11:0] cnt;
    logic [11:0] per;
    logic [6:0] tmo;
    logic burst;
    logic halt;
    logic [5:0] pulses;
    logic peak_prev;
    logic osc;
  } ffls_regs_t;
endpackage

/* ffls_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module ffls_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } ffls_sync_t;

  ffls_sync_t r;
  ffls_sync_t next_r;

  always_comb
  begin
    next_r = r;
    next_r.s1 = async_in;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    // A change counts only once the second and third stage agree
    for (int i = 0; i < W; i++)
    begin
      if (r.s2[i] == r.s3[i])
      begin
        next_r.q[i] = r.s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign sync_out = r.q;
endmodule // ffls_sync
`default_nettype wire

/* ffls_sequencer.sv */
// Light-load mode sequencer: foldback blanking, oscillator blanking and burst supervisor
// Function
// - Hold blanking step; move only to adjacent step
// - Force clamp after 2 us low-demag timeout
// - Longest blanking step equals ten base units
// - Oscillator active only in longest step
// - Oscillator at step 4-5 threshold: 80e-3/base
// - Oscillator gives 25 kHz at burst boundary
// - Oscillator blanking starts at main switch on
// - Outside burst, clamp after recharge only after both blankings ended
// - Clamp at first peak after both blankings
// - Timeout armed only after both blankings end
// - No clamp in recharge during oscillator mode
// - Below burst threshold: halt at next turn-off
// - Idle ends above threshold plus hysteresis
// - Each burst holds at least three cycles
// - In burst: oscillator off, fixed step-4-5 frequency
// - In burst: peak reference raised, held constant
// - Burst clamp after pulses 2,9,16,24,32 only
// - Leave burst on exit threshold or >32 cycles
// - Five steps, multiples of programmable base unit
// - Blanking lengthens stepwise as load falls
`timescale 1ns/1ps
`default_nettype none
`include "ffls_defs.svh"
module ffls_sequencer #(
  parameter logic [7:0] VCOMP_BM_CODE = `FFLS_VCOMP_BM_CODE,
  parameter logic [7:0] VCOMP_45_CODE = `FFLS_VCOMP_45_CODE
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [5:0] base_time_unit,
  input wire logic [7:0] vcomp_code,
  input wire logic cs_trip,
  input wire logic ringing_peak,
  input wire logic demag_below_trigger,
  input wire logic demag_above_arm,
  input wire logic below_burst_entry,
  input wire logic above_burst_hyst,
  input wire logic above_burst_exit,
  input wire logic step_longer_req,
  input wire logic step_shorter_req,
  output logic main_switch,
  output logic clamp_switch,
  output logic burst_active_flag,
  output logic peak_current_boost,
  output logic oscillator_mode,
  output ffls_pkg::ffls_step_t blank_step
);
  import ffls_pkg::*;

  // ==========================================================
  // Input synchronisation
  logic [8:0] raw_in;
  logic [8:0] syn;
  logic cs_s;
  logic peak_s;
  logic below_trig_s;
  logic above_arm_s;
  logic below_entry_s;
  logic above_hyst_s;
  logic exit_s;
  logic longer_s;
  logic shorter_s;

  assign raw_in = {cs_trip, ringing_peak, demag_below_trigger, demag_above_arm, below_burst_entry,
                   above_burst_hyst, above_burst_exit, step_longer_req, step_shorter_req};

  ffls_sync #(.W(9)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(raw_in),
    .sync_out(syn)
  );

  assign {cs_s, peak_s, below_trig_s, above_arm_s, below_entry_s,
          above_hyst_s, exit_s, longer_s, shorter_s} = syn;

  // ==========================================================
  // Interval arithmetic
  function automatic logic [11:0] clamp_base(input logic [5:0] b);
    logic [11:0] v;
    v = {6'h00, b};
    if (v < 12'(`FFLS_BASE_MIN_CYC))
    begin
      v = 12'(`FFLS_BASE_MIN_CYC);
    end
    else if (v > 12'(`FFLS_BASE_MAX_CYC))
    begin
      v = 12'(`FFLS_BASE_MAX_CYC);
    end
    return v;
  endfunction

  // Step k (0..4) waits (k+1)*2 base units; the longest one ten units
  function automatic logic [11:0] blank_len(input ffls_step_t s, input logic [11:0] b);
    logic [15:0] m;
    m = 16'(({13'h0000, s} + 16'h0001) * 16'(`FFLS_MULT_STEP) * {4'h0, b});
    return m[11:0];
  endfunction

  // Period at the step 4-5 threshold: base / 80e-3
  function automatic logic [11:0] per45(input logic [11:0] b);
    logic [19:0] m;
    m = 20'(({8'h00, b} * 20'(`FFLS_OSC45_DEN)) / 20'(`FFLS_OSC45_NUM));
    return m[11:0];
  endfunction

  // Period falls linearly from the burst boundary to the step 4-5 threshold
  function automatic logic [11:0] osc_len(input logic [7:0] v, input logic [11:0] b);
    logic [19:0] span;
    logic [19:0] d;
    logic [11:0] p45;
    p45 = per45(b);
    span = 20'(`FFLS_BM_PER_CYC) - {8'h00, p45};
    d = 20'h00000;
    if (v <= VCOMP_BM_CODE)
    begin
      d = 20'h00000;
    end
    else if (v >= VCOMP_45_CODE)
    begin
      d = span;
    end
    else
    begin
      d = 20'((span * {12'h000, v - VCOMP_BM_CODE}) / {12'h000, VCOMP_45_CODE - VCOMP_BM_CODE});
    end
    return 12'(20'(`FFLS_BM_PER_CYC) - d);
  endfunction

  function automatic logic clamp_sched(input logic [5:0] p);
    return (p == `FFLS_CLAMP_P1) || (p == `FFLS_CLAMP_P2) || (p == `FFLS_CLAMP_P3) ||
           (p == `FFLS_CLAMP_P4) || (p == `FFLS_CLAMP_P5);
  endfunction

  // ==========================================================
  // Sequencer state
  ffls_regs_t r;
  ffls_regs_t next_r;
  logic [11:0] base_c;
  logic [11:0] burst_per;
  logic blank_done;
  logic osc_done;
  logic both_done;
  logic peak_rise;

  always_comb
  begin
    base_c = clamp_base(base_time_unit);
    burst_per = per45(base_c);
    blank_done = r.cnt >= blank_len(r.step, base_c);
    osc_done = !r.osc || (r.per >= osc_len(vcomp_code, base_c));
    both_done = blank_done && osc_done;
    peak_rise = peak_s && !r.peak_prev;
  end

  always_comb
  begin
    next_r = r;
    next_r.peak_prev = peak_s;
    if (r.per != 12'hfff)
    begin
      next_r.per = r.per + 12'h001;
    end
    if (r.cnt != 12'hfff)
    begin
      next_r.cnt = r.cnt + 12'h001;
    end
    if (below_entry_s && r.st != ST_IDLE)
    begin
      next_r.halt = 1'b1;
    end
    if (r.burst && exit_s)
    begin
      next_r.burst = 1'b0;
    end
    case (r.st)
      ST_DEAD:
      begin
        if (r.cnt >= `FFLS_DEAD_CYC - 12'h001)
        begin
          next_r.st = ST_MAIN;
          next_r.main_sw = 1'b1;
          next_r.per = 12'h000;
          next_r.cnt = 12'h000;
          if (r.burst)
          begin
            next_r.pulses = r.pulses + 6'h01;
          end
          else if (longer_s && r.step < `FFLS_STEP_MAX)
          begin
            next_r.step = r.step + 3'h1;
          end
          else if (shorter_s && r.step != 3'h0)
          begin
            next_r.step = r.step - 3'h1;
          end
        end
      end
      ST_MAIN:
      begin
        if (cs_s)
        begin
          next_r.main_sw = 1'b0;
          next_r.cnt = 12'h000;
          if (r.halt && (!r.burst || r.pulses >= `FFLS_MIN_BURST))
          begin
            next_r.st = ST_IDLE;
            next_r.burst = 1'b1;
            next_r.halt = 1'b0;
          end
          else
          begin
            if (r.burst && r.pulses > `FFLS_MAX_BURST)
            begin
              next_r.burst = 1'b0;
            end
            next_r.st = ST_RECH;
            next_r.clamp_sw = !r.osc && !r.burst;
          end
        end
      end
      ST_RECH:
      begin
        if (r.cnt >= `FFLS_RECH_CYC - 12'h001)
        begin
          next_r.clamp_sw = 1'b0;
          next_r.st = ST_WAIT;
          next_r.cnt = 12'h000;
          next_r.tmo = 7'h00;
        end
      end
      ST_WAIT:
      begin
        // One extra cycle covers the state change, so main-on to main-on is exactly burst_per
        if (r.burst)
        begin
          if (clamp_sched(r.pulses))
          begin
            if (r.per + `FFLS_DEAD_CYC + `FFLS_REV_CYC + 12'h001 >= burst_per)
            begin
              next_r.st = ST_CLAMP;
              next_r.clamp_sw = 1'b1;
              next_r.cnt = 12'h000;
            end
          end
          else if (r.per + `FFLS_DEAD_CYC + 12'h001 >= burst_per)
          begin
            next_r.st = ST_DEAD;
            next_r.cnt = 12'h000;
          end
        end
        else if (both_done)
        begin
          if (peak_rise)
          begin
            next_r.st = ST_CLAMP;
            next_r.clamp_sw = 1'b1;
            next_r.cnt = 12'h000;
          end
          else if (below_trig_s && !above_arm_s)
          begin
            if (r.tmo >= 7'(`FFLS_FRT_CYC) - 7'h01)
            begin
              next_r.st = ST_CLAMP;
              next_r.clamp_sw = 1'b1;
              next_r.cnt = 12'h000;
            end
            else
            begin
              next_r.tmo = r.tmo + 7'h01;
            end
          end
          else
          begin
            next_r.tmo = 7'h00;
          end
        end
        else
        begin
          next_r.tmo = 7'h00;
        end
      end
      ST_CLAMP:
      begin
        if (r.cnt >= `FFLS_REV_CYC - 12'h001)
        begin
          next_r.clamp_sw = 1'b0;
          next_r.st = ST_DEAD;
          next_r.cnt = 12'h000;
        end
      end
      ST_IDLE:
      begin
        if (above_hyst_s)
        begin
          next_r.st = ST_DEAD;
          next_r.cnt = 12'h000;
          next_r.pulses = 6'h00;
        end
      end
      default:
      begin
        next_r = '0;
      end
    endcase
    next_r.osc = (next_r.step == `FFLS_STEP_MAX) && !next_r.burst;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign main_switch = r.main_sw;
  assign clamp_switch = r.clamp_sw;
  assign burst_active_flag = r.burst;
  assign peak_current_boost = r.burst;
  assign oscillator_mode = r.osc;
  assign blank_step = r.step;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_step_adjacent: assert property (r.step != $past(r.step) |->
    (r.step == $past(r.step) + 3'h1) || (r.step + 3'h1 == $past(r.step)))
    else $error("blanking step jumped");

  chk_step_range: assert property (r.step <= `FFLS_STEP_MAX)
    else $error("blanking step out of range");

  chk_long_blank: assert property (r.st == ST_WAIT && !r.burst && r.step == `FFLS_STEP_MAX
    && next_r.st == ST_CLAMP |-> r.cnt >= 12'(`FFLS_LONG_MULT) * base_c)
    else $error("clamp before ten base units");

  chk_osc_only_long: assert property (r.osc |-> r.step == `FFLS_STEP_MAX && !r.burst)
    else $error("oscillator outside longest step");

  chk_timeout_armed: assert property ($past(r.st) == ST_WAIT && r.st == ST_WAIT && !$past(r.burst)
    && !$past(both_done) |-> r.tmo == 7'h00)
    else $error("timeout ran before both blankings ended");

  chk_wait_clamp_blank: assert property ($past(r.st) == ST_WAIT && !$past(r.burst) && r.st == ST_CLAMP
    |-> $past(both_done))
    else $error("clamp before both blankings");

  chk_timeout_len: assert property ($past(r.st) == ST_WAIT && !$past(r.burst) && r.st == ST_CLAMP
    && !$past(peak_rise) |-> $past(r.tmo) == 7'(`FFLS_FRT_CYC) - 7'h01)
    else $error("timeout clamp at wrong count");

  chk_no_recharge_clamp: assert property (r.st == ST_RECH && r.osc |-> !r.clamp_sw)
    else $error("clamp in recharge during oscillator mode");

  chk_halt_stops: assert property (r.st == ST_MAIN && cs_s && r.halt && !r.burst
    |=> r.st == ST_IDLE && !r.main_sw && r.burst)
    else $error("halt did not stop switching");

  chk_burst_min_three: assert property (r.st == ST_MAIN && r.burst && r.pulses < `FFLS_MIN_BURST
    && cs_s |=> r.st != ST_IDLE)
    else $error("burst shorter than three cycles");

  chk_burst_clamp_sched: assert property (r.burst && $rose(r.clamp_sw) |-> clamp_sched(r.pulses))
    else $error("burst clamp outside schedule");

  chk_burst_exit_long: assert property (r.st == ST_MAIN && r.burst && cs_s && !r.halt
    && r.pulses > `FFLS_MAX_BURST |=> !r.burst)
    else $error("burst not left after 32 cycles");

  cov_burst_entry: cover property ($rose(r.burst));
  cov_timeout_clamp: cover property (r.st == ST_WAIT && !r.burst ##1 r.st == ST_CLAMP && !$past(peak_rise));
  cov_osc_mode: cover property (r.osc && r.st == ST_WAIT ##1 r.st == ST_CLAMP);
  cov_burst_exit: cover property ($fell(r.burst));
endmodule // ffls_sequencer
`default_nettype wire

/* ffls_power_stage.sv */
// Power stage and gate driver model facing the light-load sequencer
`timescale 1ns/1ps
`default_nettype none
module ffls_power_stage #(
  parameter int ON_CYC = 20,
  parameter int DEMAG_CYC = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic main_switch,
  input wire logic clamp_switch,
  input wire logic ring_en,
  output logic cs_trip,
  output logic ringing_peak,
  output logic demag_below_trigger,
  output logic demag_above_arm
);
  int on_n;
  int off_n;
  // ==========================================
  // Magnetising and demagnetising time counters
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      on_n <= 0;
      off_n <= 0;
    end
    else
    begin
      on_n <= main_switch ? on_n + 1 : 0;
      off_n <= main_switch ? 0 : off_n + 1;
    end
  end
  // ==========================================
  // Comparator outputs
  assign cs_trip = main_switch && (on_n >= ON_CYC);
  // Secondary conducts briefly after turn-off, then the pin rings only when enabled
  assign demag_above_arm = !main_switch && (off_n < DEMAG_CYC);
  assign demag_below_trigger = !demag_above_arm;
  assign ringing_peak = ring_en && !demag_above_arm && !main_switch && !clamp_switch && (off_n % 10 >= 5);
endmodule // ffls_power_stage
`default_nettype wire

/* ffls_sequencer_tb.sv */
// Self-checking bench of the light-load sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; $display("BAD %0t mismatch", $time); end end
`define RNG(x, lo, hi) `CHK(((x) >= (lo)) && ((x) <= (hi)), 1'b1)
module ffls_sequencer_tb;
  import ffls_pkg::*;
  logic clk = 0;
  logic rst_n = 0;
  logic cs_trip, ringing_peak, demag_below_trigger, demag_above_arm;
  logic below_burst_entry = 0, above_burst_hyst = 0, above_burst_exit = 0;
  logic step_longer_req = 0, step_shorter_req = 0, ring_en = 0;
  logic [5:0] base_time_unit = 6'h10;
  logic [7:0] vcomp_code = 8'hff;
  logic main_switch, clamp_switch, burst_active_flag, peak_current_boost, oscillator_mode;
  ffls_step_t blank_step;
  int err_count = 0;
  int checks_done = 0;
  int n, cnt, per, cl, e;
  always #25 clk = ~clk;
  ffls_sequencer ffls_sequencer_inst (.clk(clk), .rst_n(rst_n), .base_time_unit(base_time_unit),
    .vcomp_code(vcomp_code), .cs_trip(cs_trip), .ringing_peak(ringing_peak),
    .demag_below_trigger(demag_below_trigger), .demag_above_arm(demag_above_arm),
    .below_burst_entry(below_burst_entry), .above_burst_hyst(above_burst_hyst),
    .above_burst_exit(above_burst_exit), .step_longer_req(step_longer_req),
    .step_shorter_req(step_shorter_req), .main_switch(main_switch), .clamp_switch(clamp_switch),
    .burst_active_flag(burst_active_flag), .peak_current_boost(peak_current_boost),
    .oscillator_mode(oscillator_mode), .blank_step(blank_step));
  ffls_power_stage ffls_power_stage_inst (.clk(clk), .rst_n(rst_n), .main_switch(main_switch),
    .clamp_switch(clamp_switch), .ring_en(ring_en), .cs_trip(cs_trip), .ringing_peak(ringing_peak),
    .demag_below_trigger(demag_below_trigger), .demag_above_arm(demag_above_arm));
  // ==========================================
  // Helpers
  task automatic test_done();
    if (err_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  function automatic logic sel(input int s);
    case (s)
      0: return main_switch;
      1: return clamp_switch;
      default: return burst_active_flag;
    endcase
  endfunction
  // Counts falling edges until the output reaches v; -1 when the bound runs out
  task automatic wt(input int s, input logic v, input int lim, input bit must, output int k);
    k = 0;
    while (sel(s) !== v)
    begin
      @(negedge clk);
      k++;
      if (k > lim)
      begin
        k = -1;
        if (must)
        begin
          err_count++;
          $display("BAD %0t wait expired", $time);
          test_done();
        end
        return;
      end
    end
  endtask
  // ==========================================
  // Scenarios
  initial
  begin
    repeat (10) @(negedge clk);
    rst_n = 1;
    `CHK(main_switch, 1'b0)
    wt(0, 1'b1, 10, 1, n);
    `RNG(n, 1, 3)
    // Shortest step, no ringing: timeout ends the wait
    wt(0, 1'b0, 200, 1, n);
    `CHK(clamp_switch, 1'b1)
    wt(1, 1'b0, 20, 1, n);
    `RNG(n, 3, 5)
    wt(1, 1'b1, 300, 1, n);
    `RNG(n, 70, 76)
    // Step walk: up to the end, one down, one up
    vcomp_code = 8'hc0;
    for (int k = 1; k <= 7; k++)
    begin
      step_longer_req = (k != 6);
      step_shorter_req = (k == 6);
      wt(0, 1'b0, 3000, 1, n);
      wt(0, 1'b1, 3000, 1, n);
      @(negedge clk);
      e = (k == 6) ? 3 : (k > 4 ? 4 : k);
      `CHK(blank_step, ffls_step_t'(e))
      `CHK(oscillator_mode, 1'(e == 4))
    end
    step_longer_req = 0;
    step_shorter_req = 0;
    // Oscillator period at both ends, with ringing present
    ring_en = 1;
    for (int k = 0; k < 2; k++)
    begin
      vcomp_code = k ? 8'h40 : 8'hc0;
      per = k ? 800 : 200;
      wt(0, 1'b0, 3000, 1, n);
      wt(0, 1'b1, 3000, 1, n);
      wt(1, 1'b1, 3000, 1, n);
      `RNG(n, per - 2, per + 18)
    end
    // Burst entry and idle
    ring_en = 0;
    vcomp_code = 8'h30;
    below_burst_entry = 1;
    wt(2, 1'b1, 3000, 1, n);
    `CHK(main_switch, 1'b0)
    @(negedge clk);
    `CHK(peak_current_boost, 1'b1)
    `CHK(oscillator_mode, 1'b0)
    wt(0, 1'b1, 300, 0, n);
    `CHK(n, -1)
    // Long burst: clamp pattern, period, exit after pulse 33
    below_burst_entry = 0;
    above_burst_hyst = 1;
    vcomp_code = 8'h80;
    wt(0, 1'b1, 300, 1, n);
    for (int p = 1; p <= 32; p++)
    begin
      wt(0, 1'b0, 300, 1, n);
      cl = 0;
      cnt = 0;
      while (main_switch !== 1'b1 && cnt < 400)
      begin
        @(negedge clk);
        cnt++;
        if (clamp_switch === 1'b1)
          cl = 1;
      end
      `RNG(n + cnt, 197, 203)
      if (cnt >= 400)
        test_done();
      e = int'(p inside {2, 9, 16, 24, 32});
      `CHK(cl, e)
      `CHK(burst_active_flag, 1'b1)
    end
    wt(0, 1'b0, 300, 1, n);
    @(negedge clk);
    `CHK(burst_active_flag, 1'b0)
    // Short burst at the longest base unit: halt already pending, still three pulses
    vcomp_code = 8'h30;
    base_time_unit = 6'h2c;
    above_burst_hyst = 0;
    below_burst_entry = 1;
    wt(2, 1'b1, 3000, 1, n);
    above_burst_hyst = 1;
    wt(0, 1'b1, 300, 1, n);
    above_burst_hyst = 0;
    cnt = 1;
    n = 0;
    while (n >= 0 && cnt < 40)
    begin
      wt(0, 1'b0, 300, 1, per);
      wt(0, 1'b1, 700, 0, n);
      if (n >= 0)
      begin
        cnt++;
        `RNG(n + per, 548, 552)
      end
    end
    `CHK(cnt, 3)
    // Exit on the exit threshold
    below_burst_entry = 0;
    above_burst_exit = 1;
    above_burst_hyst = 1;
    vcomp_code = 8'hd0;
    wt(2, 1'b0, 600, 1, n);
    `CHK(peak_current_boost, 1'b0)
    test_done();
  end
endmodule // ffls_sequencer_tb
`default_nettype wire
